// File: src/csf_flag_unit.sv
// Next-value logic for the four arithmetic flags
`timescale 1ns/1ps
module csf_flag_unit
  import csf_pkg::*;
(
  input wire csf_arith_t cur, // Flags held now
  input wire logic sw_we, // Software writes low byte
  input wire csf_arith_t sw_val, // Flags written by software
  input wire csf_upd_t upd, // Per-flag update strobes from ALU
  input wire csf_arith_t res, // Result flags from ALU
  output csf_arith_t nxt // Next flag values
);

  always_comb begin
    nxt = sw_we ? sw_val : cur;
    // ALU update takes precedence over a software write
    if (upd.neg_we) begin
      nxt.neg = res.neg;
    end
    if (upd.ovf_we) begin
      nxt.ovf = res.ovf;
    end
    if (upd.zero_we) begin
      // Sticky mode: zero result keeps flag, nonzero clears
      if (!res.zero) begin
        nxt.zero = 1'b0;
      end else if (!upd.zero_sticky) begin
        nxt.zero = 1'b1;
      end else begin
        nxt.zero = cur.zero;
      end
    end
    if (upd.carry_we) begin
      nxt.carry = res.carry;
    end
  end

endmodule

// File: src/csf_pkg.sv
// Package of constants and types for the CPU status flag register bank
package csf_pkg;

  // ==========================================================
  // Bus geometry
  // ==========================================================
  localparam int CSF_ADDR_W = 4;
  localparam int CSF_DATA_W = 32;
  localparam int CSF_BE_W = 4;

  // ==========================================================
  // Register byte offsets
  // ==========================================================
  localparam logic [3:0] CSF_OFS_STATUS = 4'h0;
  localparam logic [3:0] CSF_OFS_CORE_CTRL = 4'h4;
  localparam logic [3:0] CSF_OFS_INT_CTRL = 4'h8;

  // ==========================================================
  // Status word fields
  // ==========================================================
  localparam int CSF_PRIO_LSB = 5;
  localparam int CSF_PRIO_MSB = 7;
  localparam int CSF_BIT_REPEAT = 4;
  localparam int CSF_BIT_NEG = 3;
  localparam int CSF_BIT_OVF = 2;
  localparam int CSF_BIT_ZERO = 1;
  localparam int CSF_BIT_CARRY = 0;
  localparam int CSF_BIT_SAT_A = 13;
  localparam int CSF_BIT_SAT_B = 12;
  localparam int CSF_BIT_SAT_AB = 11;

  // Core control and interrupt control fields
  localparam int CSF_BIT_PRIO_MSB = 3;
  localparam int CSF_BIT_NEST_DIS = 15;

  // Priority code that masks every user interrupt
  localparam logic [2:0] CSF_PRIO_TOP = 3'h7;

  // ==========================================================
  // Values after reset
  // ==========================================================
  localparam logic [2:0] CSF_RST_PRIO = 3'h0;
  localparam logic CSF_RST_PRIO_MSB = 1'b0;
  localparam logic CSF_RST_NEST_DIS = 1'b0;
  localparam logic CSF_RST_FLAG = 1'b0;

  // ==========================================================
  // Types
  // ==========================================================
  typedef struct packed {
    logic neg;
    logic ovf;
    logic zero;
    logic carry;
  } csf_arith_t;

  typedef struct packed {
    logic neg_we;
    logic ovf_we;
    logic zero_we;
    logic zero_sticky;
    logic carry_we;
  } csf_upd_t;

  typedef enum logic [1:0] {
    CSF_BUS_IDLE = 2'b01,
    CSF_BUS_ACK = 2'b10
  } csf_bus_st_t;

endpackage

// File: src/csf_status_regs.sv
// CPU status word register bank with Avalon-MM slave
//
// The Avalon-MM register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module csf_status_regs
  import csf_pkg::*;
(
  input wire logic clk, // Processor clock
  input wire logic rst, // Async reset, active high
  input wire logic [CSF_ADDR_W-1:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [CSF_DATA_W-1:0] avs_writedata, // Write data
  input wire logic [CSF_BE_W-1:0] avs_byteenable, // Byte enables
  output logic [CSF_DATA_W-1:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall request
  input wire csf_upd_t alu_upd, // Flag update strobes
  input wire csf_arith_t alu_res, // ALU result flags
  input wire logic repeat_busy, // Repeat loop executing
  input wire logic sat_a_set, // Accumulator A saturated
  input wire logic sat_b_set, // Accumulator B saturated
  input wire logic prio_load, // Exception unit loads priority
  input wire logic [3:0] prio_value, // Priority to load
  output logic [15:0] status_word, // Full status word
  output logic [3:0] cpu_priority, // Four-bit priority level
  output logic user_irq_block // User interrupts masked
);

  // ==========================================================
  // State
  // ==========================================================
  csf_bus_st_t bus_st_ff;
  csf_bus_st_t nxt_bus_st;
  logic [CSF_DATA_W-1:0] rdata_ff;
  logic [CSF_DATA_W-1:0] nxt_rdata;
  logic [2:0] prio_ff;
  logic [2:0] nxt_prio;
  logic prio_msb_ff;
  logic nxt_prio_msb;
  logic nest_dis_ff;
  logic nxt_nest_dis;
  logic repeat_ff;
  logic nxt_repeat;
  logic sat_a_ff;
  logic nxt_sat_a;
  logic sat_b_ff;
  logic nxt_sat_b;
  csf_arith_t arith_ff;
  csf_arith_t nxt_arith;
  csf_arith_t sw_arith;
  logic bus_req;
  logic bus_acc;
  logic wr_acc;
  logic wr_status;
  logic wr_status_lo;
  logic wr_status_hi;
  logic wr_core;
  logic wr_int;
  logic [15:0] status_view;

  // ==========================================================
  // Bus handshake
  // ==========================================================
  assign bus_req = avs_read | avs_write;
  assign avs_waitrequest = bus_req & (bus_st_ff == CSF_BUS_IDLE);
  assign bus_acc = bus_req & (bus_st_ff == CSF_BUS_ACK);
  assign wr_acc = avs_write & bus_acc;
  assign wr_status = wr_acc & (avs_address == CSF_OFS_STATUS);
  assign wr_status_lo = wr_status & avs_byteenable[0];
  assign wr_status_hi = wr_status & avs_byteenable[1];
  assign wr_core = wr_acc & (avs_address == CSF_OFS_CORE_CTRL)
                   & avs_byteenable[0];
  assign wr_int = wr_acc & (avs_address == CSF_OFS_INT_CTRL)
                  & avs_byteenable[1];
  assign avs_readdata = rdata_ff;

  always_comb begin
    nxt_bus_st = bus_st_ff;
    case (bus_st_ff)
      CSF_BUS_IDLE: begin
        if (bus_req) begin
          nxt_bus_st = CSF_BUS_ACK;
        end
      end
      CSF_BUS_ACK: begin
        nxt_bus_st = CSF_BUS_IDLE;
      end
      default: begin
        nxt_bus_st = CSF_BUS_IDLE;
      end
    endcase
  end

  // ==========================================================
  // Status word view
  // ==========================================================
  always_comb begin
    status_view = 16'h0000;
    status_view[CSF_PRIO_MSB:CSF_PRIO_LSB] = prio_ff;
    status_view[CSF_BIT_REPEAT] = repeat_ff;
    status_view[CSF_BIT_NEG] = arith_ff.neg;
    status_view[CSF_BIT_OVF] = arith_ff.ovf;
    status_view[CSF_BIT_ZERO] = arith_ff.zero;
    status_view[CSF_BIT_CARRY] = arith_ff.carry;
    status_view[CSF_BIT_SAT_A] = sat_a_ff;
    status_view[CSF_BIT_SAT_B] = sat_b_ff;
    status_view[CSF_BIT_SAT_AB] = sat_a_ff | sat_b_ff;
  end

  assign status_word = status_view;
  assign cpu_priority = {prio_msb_ff, prio_ff};
  assign user_irq_block = (prio_ff == CSF_PRIO_TOP) | prio_msb_ff;

  // ==========================================================
  // Read data, captured while the request waits
  // ==========================================================
  always_comb begin
    nxt_rdata = rdata_ff;
    if (avs_read && bus_st_ff == CSF_BUS_IDLE) begin
      nxt_rdata = '0;
      case (avs_address)
        CSF_OFS_STATUS: begin
          nxt_rdata[15:0] = status_view;
        end
        CSF_OFS_CORE_CTRL: begin
          nxt_rdata[CSF_BIT_PRIO_MSB] = prio_msb_ff;
        end
        CSF_OFS_INT_CTRL: begin
          nxt_rdata[CSF_BIT_NEST_DIS] = nest_dis_ff;
        end
        default: begin
          nxt_rdata = '0;
        end
      endcase
    end
  end

  // ==========================================================
  // Priority, control bits and saturation flags
  // ==========================================================
  always_comb begin
    nxt_prio = prio_ff;
    nxt_prio_msb = prio_msb_ff;
    nxt_nest_dis = nest_dis_ff;
    nxt_repeat = repeat_busy;
    nxt_sat_a = sat_a_ff;
    nxt_sat_b = sat_b_ff;
    // Locked field ignores software while nesting is disabled
    if (wr_status_lo && !nest_dis_ff) begin
      nxt_prio = avs_writedata[CSF_PRIO_MSB:CSF_PRIO_LSB];
    end
    if (wr_core) begin
      nxt_prio_msb = avs_writedata[CSF_BIT_PRIO_MSB];
    end
    if (wr_int) begin
      nxt_nest_dis = avs_writedata[CSF_BIT_NEST_DIS];
    end
    // Exception entry and return override software
    if (prio_load) begin
      nxt_prio = prio_value[2:0];
      nxt_prio_msb = prio_value[3];
    end
    // Clearing the combined flag clears both
    if (wr_status_hi) begin
      nxt_sat_a = avs_writedata[CSF_BIT_SAT_A]
                  & avs_writedata[CSF_BIT_SAT_AB];
      nxt_sat_b = avs_writedata[CSF_BIT_SAT_B]
                  & avs_writedata[CSF_BIT_SAT_AB];
    end
    // Hardware set wins over a software clear
    if (sat_a_set) begin
      nxt_sat_a = 1'b1;
    end
    if (sat_b_set) begin
      nxt_sat_b = 1'b1;
    end
  end

  // ==========================================================
  // Arithmetic flags
  // ==========================================================
  always_comb begin
    sw_arith.neg = avs_writedata[CSF_BIT_NEG];
    sw_arith.ovf = avs_writedata[CSF_BIT_OVF];
    sw_arith.zero = avs_writedata[CSF_BIT_ZERO];
    sw_arith.carry = avs_writedata[CSF_BIT_CARRY];
  end

  csf_flag_unit u_flags (
    .cur(arith_ff),
    .sw_we(wr_status_lo),
    .sw_val(sw_arith),
    .upd(alu_upd),
    .res(alu_res),
    .nxt(nxt_arith)
  );

  // ==========================================================
  // Registers
  // ==========================================================
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_st_ff <= CSF_BUS_IDLE;
      rdata_ff <= '0;
      prio_ff <= CSF_RST_PRIO;
      prio_msb_ff <= CSF_RST_PRIO_MSB;
      nest_dis_ff <= CSF_RST_NEST_DIS;
      repeat_ff <= CSF_RST_FLAG;
      sat_a_ff <= CSF_RST_FLAG;
      sat_b_ff <= CSF_RST_FLAG;
      arith_ff <= '0;
    end else begin
      bus_st_ff <= nxt_bus_st;
      rdata_ff <= nxt_rdata;
      prio_ff <= nxt_prio;
      prio_msb_ff <= nxt_prio_msb;
      nest_dis_ff <= nxt_nest_dis;
      repeat_ff <= nxt_repeat;
      sat_a_ff <= nxt_sat_a;
      sat_b_ff <= nxt_sat_b;
      arith_ff <= nxt_arith;
    end
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_prio_write;
    wr_status_lo && !prio_load;
  endsequence

  sequence s_sat_clear;
    wr_status_hi && !avs_writedata[CSF_BIT_SAT_AB]
      && !sat_a_set && !sat_b_set;
  endsequence

  a_prio_field_write: assert property (
    s_prio_write and !nest_dis_ff |=>
      status_word[7:5] == $past(avs_writedata[7:5]))
    else $error("priority field not written");

  a_prio_top_block: assert property (
    status_word[7:5] == 3'h7 |-> user_irq_block)
    else $error("top priority code does not block");

  a_prio_four_bit: assert property (
    prio_load |=> cpu_priority == $past(prio_value))
    else $error("four-bit priority wrong after load");

  a_msb_block_irq: assert property (
    cpu_priority[3] |-> user_irq_block)
    else $error("priority msb does not block");

  a_repeat_follows: assert property (
    ##1 status_word[4] == $past(repeat_busy))
    else $error("repeat flag does not follow loop");

  a_neg_update: assert property (
    alu_upd.neg_we |=> status_word[3] == $past(alu_res.neg))
    else $error("negative flag wrong");

  a_ovf_update: assert property (
    alu_upd.ovf_we |=> status_word[2] == $past(alu_res.ovf))
    else $error("overflow flag wrong");

  a_zero_sticky_hold: assert property (
    alu_upd.zero_we && alu_res.zero && status_word[1]
      |=> status_word[1])
    else $error("zero flag lost while sticky");

  a_zero_clear_nz: assert property (
    alu_upd.zero_we && !alu_res.zero |=> !status_word[1])
    else $error("zero flag not cleared");

  a_carry_update: assert property (
    alu_upd.carry_we |=> status_word[0] == $past(alu_res.carry))
    else $error("carry flag wrong");

  a_prio_locked: assert property (
    s_prio_write and nest_dis_ff |=> $stable(status_word[7:5]))
    else $error("priority written while locked");

  a_sat_cleared: assert property (
    s_sat_clear |=> !status_word[13] && !status_word[12]
      && !status_word[11])
    else $error("saturation flags not cleared");

  a_wait_bounded: assert property (
    bus_req |-> ##[0:1] !avs_waitrequest)
    else $error("waitrequest held too long");

endmodule

// File: verif/csf_alu_model.sv
// Execution unit model that adds two bytes and reports the flags
`timescale 1ns/1ps
module csf_alu_model
  import csf_pkg::*;
(
  input wire logic go, // One addition this cycle
  input wire logic sticky, // Zero keeps value on zero result
  input wire logic [7:0] op_a, // First operand
  input wire logic [7:0] op_b, // Second operand
  output csf_upd_t upd, // Flag update strobes
  output csf_arith_t res // Result flags
);
  logic [8:0] sum;

  always_comb begin
    sum = {1'b0, op_a} + {1'b0, op_b};
    res.neg = sum[7];
    res.ovf = (op_a[7] == op_b[7]) && (sum[7] != op_a[7]);
    res.zero = (sum[7:0] == 8'h00);
    res.carry = sum[8];
    upd.neg_we = go;
    upd.ovf_we = go;
    upd.zero_we = go;
    upd.zero_sticky = sticky;
    upd.carry_we = go;
  end
endmodule

// File: verif/tb.sv
// Self-checking bench for the status word register bank
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
  fail_count++; $display("ERROR t=%0t got %0h exp %0h", $time, g, e); \
  end end
module tb
  import csf_pkg::*;
;
  logic clk, rst, avs_read, avs_write, avs_waitrequest, rep_busy;
  logic sat_a, sat_b, prio_load, go, sticky, user_irq_block;
  logic [3:0] avs_address, prio_value, cpu_priority;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [7:0] op_a, op_b;
  logic [15:0] status_word;
  csf_upd_t upd;
  csf_arith_t res;
  int fail_count, total_checks, cyc, seed;
  // Reference state
  logic [2:0] m_prio;
  logic [3:0] m_fl;
  logic m_msb, m_rep, m_sa, m_sb, m_nest;

  csf_status_regs csf_status_regs_i (.clk(clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'h3), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .alu_upd(upd), .alu_res(res),
    .repeat_busy(rep_busy), .sat_a_set(sat_a), .sat_b_set(sat_b),
    .prio_load(prio_load), .prio_value(prio_value),
    .status_word(status_word), .cpu_priority(cpu_priority),
    .user_irq_block(user_irq_block));
  csf_alu_model csf_alu_model_i (.go(go), .sticky(sticky), .op_a(op_a),
    .op_b(op_b), .upd(upd), .res(res));

  // ==========================================================
  // Clock, timeout, verdict
  // ==========================================================
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  // ==========================================================
  // Helpers
  // ==========================================================
  function automatic logic [15:0] exp_sw();
    return {2'b0, m_sa, m_sb, m_sa | m_sb, 3'b0, m_prio, m_rep, m_fl};
  endfunction

  task bus(input logic wr, input logic [3:0] ad, input logic [31:0] d);
    @(posedge clk);
    avs_address <= ad;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    // Hold the request until waitrequest is seen low at a rising edge
    do @(posedge clk); while (avs_waitrequest);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task wr_status(input logic [15:0] d);
    bus(1'b1, CSF_OFS_STATUS, {16'h0, d});
    if (!m_nest) m_prio = d[7:5];
    m_fl = d[3:0];
    m_sa = d[13] & d[11];
    m_sb = d[12] & d[11];
  endtask

  task look();
    @(posedge clk);
    @(negedge clk);
    `CHK(status_word, exp_sw())
    `CHK(cpu_priority, {m_msb, m_prio})
    `CHK(user_irq_block, (m_prio == 3'h7) | m_msb)
  endtask

  task add(input logic [7:0] a, input logic [7:0] b, input logic st);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    @(posedge clk);
    go <= 1'b1;
    op_a <= a;
    op_b <= b;
    sticky <= st;
    @(posedge clk);
    go <= 1'b0;
    m_fl[3] = s[7];
    m_fl[2] = (a[7] == b[7]) && (s[7] != a[7]);
    m_fl[0] = s[8];
    if (s[7:0] != 8'h00) m_fl[1] = 1'b0;
    else if (!st) m_fl[1] = 1'b1;
    @(negedge clk);
    `CHK(status_word[3:0], m_fl)
  endtask

  task hw(input logic [3:0] pv, input logic sa, input logic sb);
    @(posedge clk);
    prio_load <= (pv != 4'hf);
    prio_value <= pv;
    sat_a <= sa;
    sat_b <= sb;
    @(posedge clk);
    {prio_load, sat_a, sat_b} <= 3'b000;
    if (pv != 4'hf) {m_msb, m_prio} = pv;
    m_sa = m_sa | sa;
    m_sb = m_sb | sb;
    look();
  endtask

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    seed = 93;
    {avs_read, avs_write, rep_busy, sat_a, sat_b, prio_load} = 6'h0;
    {go, sticky, op_a, op_b, avs_address} = '0;
    {avs_writedata, prio_value} = '0;
    {m_prio, m_fl, m_msb, m_rep, m_sa, m_sb, m_nest} = '0;
    rst = 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    look();
    // Fixed corner sums, then random ones
    add(8'h00, 8'h00, 1'b0);
    add(8'h80, 8'h80, 1'b1);
    add(8'h7f, 8'h01, 1'b0);
    add(8'h00, 8'h00, 1'b1);
    add(8'hff, 8'h01, 1'b1);
    repeat (40) begin
      add(8'($random(seed)), 8'($random(seed)), 1'($random(seed)));
    end
    // Repeat loop indicator follows the busy level
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      rep_busy <= ~rep_busy;
      m_rep = ~m_rep;
      look();
    end
    // Every priority code with the extra bit clear and set
    for (int k = 0; k < 16; k++) begin
      bus(1'b1, CSF_OFS_CORE_CTRL, {28'h0, k[3], 3'h0});
      m_msb = k[3];
      wr_status({exp_sw()} & 16'hff1f | {8'h0, k[2:0], 5'h0});
      look();
    end
    bus(1'b0, CSF_OFS_STATUS, 32'h0);
    `CHK(q, {16'h0, exp_sw()})
    // Locked priority field ignores writes, hardware load still works
    bus(1'b1, CSF_OFS_INT_CTRL, 32'h0000_8000);
    m_nest = 1'b1;
    wr_status(exp_sw() ^ 16'h0060);
    look();
    hw(4'h5, 1'b0, 1'b0);
    bus(1'b1, CSF_OFS_INT_CTRL, 32'h0);
    m_nest = 1'b0;
    hw(4'h0, 1'b0, 1'b0);
    // Saturation flags: only whole-word writes, never bit operations
    hw(4'hf, 1'b1, 1'b0);
    wr_status(exp_sw() & 16'hf7ff);
    look();
    hw(4'hf, 1'b0, 1'b1);
    wr_status(exp_sw() | 16'h3800);
    look();
    // Unmapped address reads as zero
    bus(1'b0, 4'hc, 32'h0);
    `CHK(q, 32'h0)
    tally_and_finish();
  end
endmodule
